// [hdl/pbc_pkg.sv]
// package for the phy basic control register set
// assumes a 16-bit word, 5-bit register index management port
package pbc_pkg;

  localparam int unsigned DATA_W = 16;
  localparam int unsigned IDX_W  = 5;

  // register indices
  localparam logic [4:0] IDX_BASIC_CONTROL    = 5'h00;
  localparam logic [4:0] IDX_BASIC_STATUS     = 5'h01;
  localparam logic [4:0] IDX_IDENTIFIER_HIGH  = 5'h02;
  localparam logic [4:0] IDX_IDENTIFIER_LOW   = 5'h03;
  localparam logic [4:0] IDX_NEG_ADVERTISE    = 5'h04;
  localparam logic [4:0] IDX_PARTNER_ABILITY  = 5'h05;
  localparam logic [4:0] IDX_NEG_EXPANSION    = 5'h06;
  localparam logic [4:0] IDX_NP_TRANSMIT      = 5'h07;
  localparam logic [4:0] IDX_NP_RECEIVE       = 5'h08;
  localparam logic [4:0] IDX_MMD_ACCESS_CTRL  = 5'h0d;
  localparam logic [4:0] IDX_MMD_ADDR_DATA    = 5'h0e;
  localparam logic [4:0] IDX_EDPD_CONFIG      = 5'h10;
  localparam logic [4:0] IDX_MODE_CTRL_STAT   = 5'h11;
  localparam logic [4:0] IDX_SPECIAL_MODES    = 5'h12;
  localparam logic [4:0] IDX_REFL_PATTERN     = 5'h18;
  localparam logic [4:0] IDX_REFL_CTRL_STAT   = 5'h19;
  localparam logic [4:0] IDX_SYMBOL_ERRORS    = 5'h1a;
  localparam logic [4:0] IDX_SPECIAL_CTRL_IND = 5'h1b;
  localparam logic [4:0] IDX_CABLE_LENGTH     = 5'h1c;
  localparam logic [4:0] IDX_IRQ_SOURCE       = 5'h1d;
  localparam logic [4:0] IDX_IRQ_MASK         = 5'h1e;
  localparam logic [4:0] IDX_SPECIAL_CTRL_ST  = 5'h1f;

  // basic control field positions
  localparam int unsigned BIT_SOFT_RESET   = 15;
  localparam int unsigned BIT_LOOP         = 14;
  localparam int unsigned BIT_RATE         = 13;
  localparam int unsigned BIT_NEG_ENABLE   = 12;
  localparam int unsigned BIT_POWER_OFF    = 11;
  localparam int unsigned BIT_NEG_RESTART  = 9;
  localparam int unsigned BIT_DUPLEX       = 8;
  localparam int unsigned BIT_COL_TEST     = 7;

  // writable bits of basic control; 10 and 6:0 are reserved
  localparam logic [15:0] CTRL_WRITE_MASK  = 16'hfb80;

  // basic status reset value (ability bits)
  localparam logic [15:0] STATUS_RESET     = 16'h7800;
  localparam logic [15:0] ZERO_WORD        = 16'h0000;

  // catch-all storage reset for the other plain registers
  localparam logic [15:0] GENERIC_RESET    = 16'h0000;

endpackage : pbc_pkg

// [hdl/pbc_reg_bank.sv]
// plain 16-bit storage for the registers other than basic control
// assumes the parent decodes the index and gives a one-cycle write strobe
`timescale 1ns/1ps
`default_nettype none
module pbc_reg_bank #(
  parameter int unsigned NUM = 32
) (
  input  wire logic                          clk,
  input  wire logic                          nrst,
  input  wire logic                          clear,
  input  wire logic                          wr_en,
  input  wire logic [pbc_pkg::IDX_W-1:0]     wr_idx,
  input  wire logic [pbc_pkg::DATA_W-1:0]    wr_data,
  input  wire logic [pbc_pkg::IDX_W-1:0]     rd_idx,
  output logic      [pbc_pkg::DATA_W-1:0]    rd_data
);
  import pbc_pkg::*;

  typedef struct packed {
    logic [NUM-1:0][DATA_W-1:0] word;
  } pbc_bank_t;

  pbc_bank_t state;
  pbc_bank_t next_state;

  // write port with soft-reset clear
  always_comb begin
    next_state = state;
    if (clear) begin
      for (int i = 0; i < NUM; i++) begin
        next_state.word[i] = GENERIC_RESET;
      end
    end else if (wr_en) begin
      next_state.word[wr_idx] = wr_data;
    end
  end

  // register the storage
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign rd_data = state.word[rd_idx];

endmodule : pbc_reg_bank
`default_nettype wire

// [hdl/pbc_phy_regs.sv]
// management register set of one integrated phy
// assumes the management logic gives one-cycle read and write strobes with a
// register index; straps are steady while reset is held; one instance per phy
`timescale 1ns/1ps
`default_nettype none
module pbc_phy_regs (
  input  wire logic                       clk,
  input  wire logic                       nrst,
  // management access, already indexed by the host-side logic
  input  wire logic                       wr_strobe,
  input  wire logic                       rd_strobe,
  input  wire logic [pbc_pkg::IDX_W-1:0]  reg_index,
  input  wire logic [pbc_pkg::DATA_W-1:0] wr_data,
  output logic      [pbc_pkg::DATA_W-1:0] rd_data,
  output logic                            rd_valid,
  // configuration straps of this phy
  input  wire logic                       strap_negotiation,
  input  wire logic                       strap_rate,
  input  wire logic                       strap_duplex,
  input  wire logic                       strap_fiber,
  // outcome of negotiation and datapath state
  input  wire logic                       neg_done,
  input  wire logic                       neg_rate,
  input  wire logic                       neg_duplex,
  input  wire logic                       tx_active,
  input  wire logic                       line_collision,
  // control outputs to the phy core
  output logic                            loop_enable,
  output logic                            power_off_request,
  output logic                            negotiation_enable,
  output logic                            negotiation_restart,
  output logic                            eff_rate_100,
  output logic                            eff_full_duplex,
  output logic                            collision_out,
  output logic                            tx_line_enable,
  output logic                            soft_reset_pulse
);
  import pbc_pkg::*;

  typedef struct packed {
    logic        loop_enable;
    logic        rate_select;
    logic        negotiation_enable;
    logic        power_off_request;
    logic        duplex_select;
    logic        collision_test_enable;
    logic        fiber_mode;
    logic        restart_pulse;
    logic        reset_pulse;
    logic [15:0] rd_data;
    logic        rd_valid;
    logic        eff_rate;
    logic        eff_duplex;
    logic        collision;
    logic        tx_line;
  } pbc_state_t;

  pbc_state_t state;
  pbc_state_t next_state;

  logic [15:0] bank_rd;
  logic        ctrl_wr;
  logic        bank_wr;

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  // true for indices that hold a register
  function automatic logic idx_mapped(input logic [4:0] idx);
    unique case (idx)
      IDX_BASIC_CONTROL, IDX_BASIC_STATUS, IDX_IDENTIFIER_HIGH,
      IDX_IDENTIFIER_LOW, IDX_NEG_ADVERTISE, IDX_PARTNER_ABILITY,
      IDX_NEG_EXPANSION, IDX_NP_TRANSMIT, IDX_NP_RECEIVE,
      IDX_MMD_ACCESS_CTRL, IDX_MMD_ADDR_DATA, IDX_EDPD_CONFIG,
      IDX_MODE_CTRL_STAT, IDX_SPECIAL_MODES, IDX_REFL_PATTERN,
      IDX_REFL_CTRL_STAT, IDX_SYMBOL_ERRORS, IDX_SPECIAL_CTRL_IND,
      IDX_CABLE_LENGTH, IDX_IRQ_SOURCE, IDX_IRQ_MASK,
      IDX_SPECIAL_CTRL_ST: idx_mapped = 1'b1;
      default:             idx_mapped = 1'b0;
    endcase
  endfunction : idx_mapped

  // true for plain writable storage (read-only ones never take writes)
  function automatic logic idx_writable(input logic [4:0] idx);
    unique case (idx)
      IDX_BASIC_STATUS, IDX_IDENTIFIER_HIGH, IDX_IDENTIFIER_LOW,
      IDX_PARTNER_ABILITY, IDX_SYMBOL_ERRORS,
      IDX_CABLE_LENGTH:    idx_writable = 1'b0;
      default:             idx_writable = idx_mapped(idx);
    endcase
  endfunction : idx_writable

  // basic control word as read back
  function automatic logic [15:0] ctrl_word(input pbc_state_t s);
    logic [15:0] w;
    w = ZERO_WORD;
    w[BIT_LOOP]       = s.loop_enable;
    w[BIT_RATE]       = s.rate_select;
    w[BIT_NEG_ENABLE] = s.negotiation_enable;
    w[BIT_POWER_OFF]  = s.power_off_request;
    w[BIT_DUPLEX]     = s.duplex_select;
    w[BIT_COL_TEST]   = s.collision_test_enable;
    // soft reset and restart always read zero since they self-clear
    ctrl_word = w;
  endfunction : ctrl_word

  ////////////////////////////////////////////////////////////////////////////
  // write decode

  assign ctrl_wr = wr_strobe && (reg_index == IDX_BASIC_CONTROL);
  assign bank_wr = wr_strobe && (reg_index != IDX_BASIC_CONTROL) &&
                   idx_writable(reg_index);

  // storage of the remaining registers, cleared by soft reset
  pbc_reg_bank #(
    .NUM (32)
  ) pbc_reg_bank_i (
    .clk     (clk),
    .nrst    (nrst),
    .clear   (state.reset_pulse),
    .wr_en   (bank_wr),
    .wr_idx  (reg_index),
    .wr_data (wr_data),
    .rd_idx  (reg_index),
    .rd_data (bank_rd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_state = state;
    next_state.restart_pulse = 1'b0;
    next_state.reset_pulse   = 1'b0;
    next_state.rd_valid      = 1'b0;

    if (state.reset_pulse) begin
      // soft reset: reload strap defaults, fiber flag survives
      next_state.loop_enable           = 1'b0;
      next_state.power_off_request     = 1'b0;
      next_state.collision_test_enable = 1'b0;
      next_state.rate_select = state.fiber_mode ? 1'b1 :
                               (strap_negotiation | strap_rate);
      next_state.negotiation_enable = state.fiber_mode ? 1'b0 :
                                      strap_negotiation;
      next_state.duplex_select = state.fiber_mode ? strap_duplex :
                                 (~strap_negotiation & strap_duplex);
    end else if (ctrl_wr) begin
      // reserved bits 10 and 6:0 are not stored; the mask is only applied to loop
      next_state.loop_enable           = wr_data[BIT_LOOP] & CTRL_WRITE_MASK[BIT_LOOP];
      next_state.rate_select           = wr_data[BIT_RATE];
      next_state.negotiation_enable    = wr_data[BIT_NEG_ENABLE] &
                                         ~state.fiber_mode;
      next_state.power_off_request     = wr_data[BIT_POWER_OFF];
      next_state.duplex_select         = wr_data[BIT_DUPLEX];
      next_state.collision_test_enable = wr_data[BIT_COL_TEST];
      next_state.restart_pulse         = wr_data[BIT_NEG_RESTART] &
                                         ~state.fiber_mode;
      next_state.reset_pulse           = wr_data[BIT_SOFT_RESET];
    end

    // read return, one cycle after the strobe
    if (rd_strobe) begin
      next_state.rd_valid = 1'b1;
      if (reg_index == IDX_BASIC_CONTROL) begin
        next_state.rd_data = ctrl_word(state);
      end else if (reg_index == IDX_BASIC_STATUS) begin
        next_state.rd_data = STATUS_RESET;
      end else if (idx_mapped(reg_index)) begin
        next_state.rd_data = bank_rd;
      end else begin
        next_state.rd_data = ZERO_WORD;                    // unmapped index
      end
    end

    // negotiated result overrides manual selection
    if (state.negotiation_enable && neg_done) begin
      next_state.eff_rate   = neg_rate;
      next_state.eff_duplex = neg_duplex;
    end else begin
      next_state.eff_rate   = state.rate_select;
      next_state.eff_duplex = state.duplex_select;
    end

    // collision and transmitter gating
    if (state.collision_test_enable) begin
      next_state.collision = tx_active;
    end else if (state.loop_enable) begin
      next_state.collision = 1'b0;
    end else begin
      next_state.collision = line_collision;
    end
    next_state.tx_line = ~state.loop_enable & ~state.power_off_request;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register, straps caught while reset is held

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= '0;
      state.fiber_mode         <= strap_fiber;
      state.rate_select        <= strap_fiber | strap_negotiation | strap_rate;
      state.negotiation_enable <= ~strap_fiber & strap_negotiation;
      state.duplex_select      <= strap_fiber ? strap_duplex :
                                  (~strap_negotiation & strap_duplex);
      state.eff_rate           <= 1'b0;
      state.tx_line            <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from flip-flops

  assign rd_data             = state.rd_data;
  assign rd_valid            = state.rd_valid;
  assign loop_enable         = state.loop_enable;
  assign power_off_request   = state.power_off_request;
  assign negotiation_enable  = state.negotiation_enable;
  assign negotiation_restart = state.restart_pulse;
  assign eff_rate_100        = state.eff_rate;
  assign eff_full_duplex     = state.eff_duplex;
  assign collision_out       = state.collision;
  assign tx_line_enable      = state.tx_line;
  assign soft_reset_pulse    = state.reset_pulse;

endmodule : pbc_phy_regs
`default_nettype wire

// [tb/pbc_props.sv]
// concurrent checks on the ports of one phy register set
// assumes straps change only while reset is held low
`timescale 1ns/1ps
`default_nettype none
module pbc_props (
  input wire logic                       clk,
  input wire logic                       nrst,
  input wire logic                       wr_strobe,
  input wire logic                       rd_strobe,
  input wire logic [pbc_pkg::IDX_W-1:0]  reg_index,
  input wire logic [pbc_pkg::DATA_W-1:0] wr_data,
  input wire logic                       rd_valid,
  input wire logic                       strap_fiber,
  input wire logic                       neg_done,
  input wire logic                       neg_rate,
  input wire logic                       neg_duplex,
  input wire logic                       tx_active,
  input wire logic                       loop_enable,
  input wire logic                       power_off_request,
  input wire logic                       negotiation_enable,
  input wire logic                       negotiation_restart,
  input wire logic                       eff_rate_100,
  input wire logic                       eff_full_duplex,
  input wire logic                       collision_out,
  input wire logic                       tx_line_enable,
  input wire logic                       soft_reset_pulse
);
  import pbc_pkg::*;
  // control write that is not swallowed by a soft reset
  wire logic ctl_wr = wr_strobe && reg_index == IDX_BASIC_CONTROL && !soft_reset_pulse;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////
  a_rd_answer: assert property (rd_strobe |=> rd_valid)
    else $error("read strobe got no answer");
  a_rd_single: assert property (!rd_strobe |=> !rd_valid)
    else $error("read answer without a strobe");
  a_srst_pulse: assert property (ctl_wr && wr_data[15] |=> soft_reset_pulse)
    else $error("soft reset write gave no pulse");
  a_srst_single: assert property (soft_reset_pulse |=> !soft_reset_pulse)
    else $error("soft reset pulse too long");
  a_ctrl_write: assert property (ctl_wr && !wr_data[15] |=>
      loop_enable == $past(wr_data[14]) && power_off_request == $past(wr_data[11])
      && negotiation_enable == ($past(wr_data[12]) && !strap_fiber))
    else $error("control levels do not follow the write");
  a_fiber_noneg: assert property (strap_fiber |-> !negotiation_enable)
    else $error("negotiation enabled in fiber mode");
  a_loop_mute: assert property ($past(loop_enable) && !$past(tx_active) |-> !collision_out)
    else $error("collision seen in loopback while idle");
  a_tx_mute: assert property ($past(nrst) |->
      tx_line_enable == !($past(loop_enable) || $past(power_off_request)))
    else $error("transmitter enable wrong");
  a_restart_pulse: assert property (ctl_wr && wr_data[9] && !wr_data[15] && !strap_fiber
      |=> negotiation_restart)
    else $error("restart write gave no pulse");
  a_neg_override: assert property (negotiation_enable && neg_done |=>
      eff_rate_100 == $past(neg_rate) && eff_full_duplex == $past(neg_duplex))
    else $error("negotiated result not applied");
endmodule : pbc_props
bind pbc_phy_regs pbc_props pbc_props_i (
  .clk(clk), .nrst(nrst), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
  .reg_index(reg_index), .wr_data(wr_data), .rd_valid(rd_valid), .strap_fiber(strap_fiber),
  .neg_done(neg_done), .neg_rate(neg_rate), .neg_duplex(neg_duplex), .tx_active(tx_active),
  .loop_enable(loop_enable), .power_off_request(power_off_request),
  .negotiation_enable(negotiation_enable), .negotiation_restart(negotiation_restart),
  .eff_rate_100(eff_rate_100), .eff_full_duplex(eff_full_duplex),
  .collision_out(collision_out), .tx_line_enable(tx_line_enable),
  .soft_reset_pulse(soft_reset_pulse)
);
`default_nettype wire

// [tb/pbc_host_model.sv]
// host side management access model for one phy register set
// assumes the bench clock; requests change just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module pbc_host_model (
  input  wire logic                       clk,
  output logic                            wr_strobe,
  output logic                            rd_strobe,
  output logic      [pbc_pkg::IDX_W-1:0]  reg_index,
  output logic      [pbc_pkg::DATA_W-1:0] wr_data,
  input  wire logic                       rd_valid,
  input  wire logic [pbc_pkg::DATA_W-1:0] rd_data
);
  import pbc_pkg::*;
  // idle request lines
  initial begin
    wr_strobe = 1'b0;
    rd_strobe = 1'b0;
    reg_index = 5'h1f;
    wr_data   = 16'hffff;
  end
  // one write; reserved control bits zeroed unless raw is set
  task automatic wr(input logic [4:0] i, input logic [15:0] d, input bit raw);
    @(posedge clk);
    wr_strobe <= 1'b1;
    reg_index <= i;
    wr_data   <= (raw || i != IDX_BASIC_CONTROL) ? d : d & CTRL_WRITE_MASK;
    @(posedge clk);
    wr_strobe <= 1'b0;
    reg_index <= ~i;
    wr_data   <= ~d;
  endtask : wr
  // one read; waits a bounded time for the answer
  task automatic rd(input logic [4:0] i, output logic [15:0] d);
    bit got;
    got = 1'b0;
    d   = 16'hxxxx;
    @(posedge clk);
    rd_strobe <= 1'b1;
    reg_index <= i;
    @(posedge clk);
    rd_strobe <= 1'b0;
    reg_index <= ~i;
    for (int n = 0; n < 4 && !got; n++) begin
      #1;
      got = (rd_valid === 1'b1);
      if (got) d = rd_data;
      else @(posedge clk);
    end
  endtask : rd
endmodule : pbc_host_model
`default_nettype wire

// [tb/tb_phy_basic_control_regs.sv]
// self-checking bench for one phy register set
// assumes the host model in pbc_host_model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module tb_phy_basic_control_regs;
  import pbc_pkg::*;
  logic              clk = 1'b0;
  logic              nrst = 1'b0;
  logic              strap_negotiation = 1'b0, strap_rate = 1'b0;
  logic              strap_duplex = 1'b0, strap_fiber = 1'b0;
  logic              neg_done = 1'b0, neg_rate = 1'b0, neg_duplex = 1'b0;
  logic              tx_active = 1'b0, line_collision = 1'b0;
  logic              wr_strobe, rd_strobe, rd_valid, loop_enable, power_off_request;
  logic              negotiation_enable, negotiation_restart, eff_rate_100;
  logic              eff_full_duplex, collision_out, tx_line_enable, soft_reset_pulse;
  logic [IDX_W-1:0]  reg_index;
  logic [DATA_W-1:0] wr_data, rd_data;
  int                miscompares = 0;
  int                tests_run = 0;
  always #5 clk = ~clk;
  pbc_phy_regs pbc_phy_regs_i (
    .clk(clk), .nrst(nrst), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
    .reg_index(reg_index), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid),
    .strap_negotiation(strap_negotiation), .strap_rate(strap_rate),
    .strap_duplex(strap_duplex), .strap_fiber(strap_fiber), .neg_done(neg_done),
    .neg_rate(neg_rate), .neg_duplex(neg_duplex), .tx_active(tx_active),
    .line_collision(line_collision), .loop_enable(loop_enable),
    .power_off_request(power_off_request), .negotiation_enable(negotiation_enable),
    .negotiation_restart(negotiation_restart), .eff_rate_100(eff_rate_100),
    .eff_full_duplex(eff_full_duplex), .collision_out(collision_out),
    .tx_line_enable(tx_line_enable), .soft_reset_pulse(soft_reset_pulse)
  );
  pbc_host_model pbc_host_model_i (
    .clk(clk), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .reg_index(reg_index),
    .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data)
  );
  ////////////////////////////////////////
  // compare helpers
  task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word
  task automatic chk_bit(input string nm, input logic e, input logic g);
    chk_word(nm, {15'h0000, e}, {15'h0000, g});
  endtask : chk_bit
  task automatic rdc(input logic [4:0] i, input logic [15:0] e, input string nm);
    logic [15:0] d;
    pbc_host_model_i.rd(i, d);
    chk_word(nm, e, d);
  endtask : rdc
  task automatic w(input logic [4:0] i, input logic [15:0] d);
    pbc_host_model_i.wr(i, d, 1'b0);
  endtask : w
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  // reset with straps {fiber, negotiation, rate, duplex}
  task automatic do_reset(input logic [3:0] s);
    @(posedge clk);
    nrst <= 1'b0;
    {strap_fiber, strap_negotiation, strap_rate, strap_duplex} <= s;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
  endtask : do_reset
  ////////////////////////////////////////
  // every strap combination gives its control default
  task automatic t_defaults;
    logic [15:0] e;
    for (int s = 0; s < 16; s++) begin
      do_reset(s[3:0]);
      e = 16'h0000;
      e[BIT_RATE] = s[3] | s[2] | s[1];
      e[BIT_NEG_ENABLE] = ~s[3] & s[2];
      e[BIT_DUPLEX] = s[3] ? s[0] : ~s[2] & s[0];
      rdc(IDX_BASIC_CONTROL, e, "ctrl default");
      chk_bit("neg enable", e[BIT_NEG_ENABLE], negotiation_enable);
    end
    rdc(IDX_BASIC_STATUS, STATUS_RESET, "status");
    $display("test defaults done");
  endtask : t_defaults
  // reserved bits, restart pulse, storage, read-only and unmapped places
  task automatic t_writes;
    do_reset(4'h0);
    pbc_host_model_i.wr(IDX_BASIC_CONTROL, 16'h7fff, 1'b1);
    #1;
    chk_bit("restart pulse", 1'b1, negotiation_restart);
    rdc(IDX_BASIC_CONTROL, 16'h7980, "ctrl all ones");
    chk_bit("loop", 1'b1, loop_enable);
    chk_bit("power off", 1'b1, power_off_request);
    chk_bit("tx enable", 1'b0, tx_line_enable);
    w(IDX_BASIC_CONTROL, 16'h0000);
    settle(2);
    chk_bit("tx enable", 1'b1, tx_line_enable);
    w(IDX_NEG_ADVERTISE, 16'ha5a5);
    rdc(IDX_NEG_ADVERTISE, 16'ha5a5, "advertise");
    w(IDX_IDENTIFIER_HIGH, 16'hffff);
    rdc(IDX_IDENTIFIER_HIGH, 16'h0000, "id high");
    w(5'h09, 16'hffff);
    rdc(5'h09, 16'h0000, "unmapped");
    $display("test writes done");
  endtask : t_writes
  // soft reset reloads straps and clears storage
  task automatic t_soft;
    do_reset(4'h1);
    w(IDX_BASIC_CONTROL, 16'h4800);
    w(IDX_NEG_ADVERTISE, 16'h1234);
    w(IDX_BASIC_CONTROL, 16'h8000);
    #1;
    chk_bit("soft pulse", 1'b1, soft_reset_pulse);
    settle(2);
    rdc(IDX_BASIC_CONTROL, 16'h0100, "ctrl after soft");
    rdc(IDX_NEG_ADVERTISE, 16'h0000, "advertise after soft");
    chk_bit("loop after soft", 1'b0, loop_enable);
    $display("test soft reset done");
  endtask : t_soft
  // fiber mode refuses negotiation
  task automatic t_fiber;
    do_reset(4'h8);
    w(IDX_BASIC_CONTROL, 16'h1100);
    rdc(IDX_BASIC_CONTROL, 16'h0100, "fiber ctrl");
    chk_bit("fiber neg", 1'b0, negotiation_enable);
    $display("test fiber done");
  endtask : t_fiber
  // negotiated versus manual speed and duplex
  task automatic t_eff;
    do_reset(4'h4);
    @(posedge clk);
    {neg_done, neg_rate, neg_duplex} <= 3'b101;
    settle(3);
    chk_bit("neg rate", 1'b0, eff_rate_100);
    chk_bit("neg duplex", 1'b1, eff_full_duplex);
    w(IDX_BASIC_CONTROL, 16'h2000);
    settle(2);
    chk_bit("manual rate", 1'b1, eff_rate_100);
    chk_bit("manual duplex", 1'b0, eff_full_duplex);
    w(IDX_BASIC_CONTROL, 16'h0100);
    settle(2);
    chk_bit("manual rate", 1'b0, eff_rate_100);
    chk_bit("manual duplex", 1'b1, eff_full_duplex);
    @(posedge clk);
    neg_done <= 1'b0;
    $display("test speed duplex done");
  endtask : t_eff
  // collision test, loopback muting and pass-through
  task automatic t_col;
    do_reset(4'h0);
    w(IDX_BASIC_CONTROL, 16'h4080);
    @(posedge clk);
    tx_active <= 1'b1;
    settle(2);
    chk_bit("col test", 1'b1, collision_out);
    w(IDX_BASIC_CONTROL, 16'h4000);
    line_collision <= 1'b1;
    settle(2);
    chk_bit("loop mute", 1'b0, collision_out);
    w(IDX_BASIC_CONTROL, 16'h0000);
    settle(2);
    chk_bit("col pass", 1'b1, collision_out);
    @(posedge clk);
    {tx_active, line_collision} <= 2'b00;
    $display("test collision done");
  endtask : t_col
  ////////////////////////////////////////
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict
  // main sequence
  initial begin
    t_defaults();
    t_writes();
    t_soft();
    t_fiber();
    t_eff();
    t_col();
    give_verdict();
  end
  // watchdog against a hang
  initial begin
    #100000;
    miscompares++;
    $display("ERROR watchdog expected finish seen hang");
    give_verdict();
  end
endmodule : tb_phy_basic_control_regs
`default_nettype wire
